/* File: src/ipc_codec.sv */
// Purpose: infrared pulse modulator and demodulator for one serial transceiver
// Assumes: uart_*, baud_clk and event_channel_n come from logic on aclk
// Notes:   rx_pin is synchronised; decoded bits are also captured into a buffer
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
module ipc_codec
    import ipc_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [4:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic      [1:0]  bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [4:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic      [31:0] rdata,
    output logic      [1:0]  rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic [1:0]  communication_mode_select,
    input  wire logic        baud_clk,
    input  wire logic        uart_txd,
    output logic             uart_rxd,
    output logic             tx_pin,
    input  wire logic        rx_pin,
    input  wire logic [3:0]  event_channel_n
);
    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [7:0]  tx_pulse_length;
        logic [7:0]  rx_pulse_filter;
        logic [3:0]  event_channel_select;
        logic        aw_have;
        logic [4:0]  aw_addr;
        logic        w_have;
        logic [7:0]  w_data;
        logic        w_be;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        baud_prev;
        logic [15:0] per_cnt;
        logic [15:0] period;
        logic [15:0] pulse_cnt;
        logic        tx_pin;
        logic        rx_last;
        logic [7:0]  run;
        logic        filt;
        logic [15:0] hold;
        logic        rxd;
        logic [7:0]  shreg;
        logic [2:0]  bitcnt;
        logic        pend;
        logic        overrun;
    } ipc_state_type;

    ipc_state_type st_ff;
    ipc_state_type nxt_st;
    ipc_mode_type  mode;
    logic          active;
    logic          modulating;
    logic          rx_sync;
    logic          src;
    logic          baud_rise;
    logic [17:0]   period_x3;
    logic [15:0]   len316;
    logic [15:0]   period_min;
    logic          fifo_in_ready;
    logic          fifo_out_valid;
    logic [7:0]    fifo_out_data;
    logic          fifo_pop;
    logic [31:0]   status_word;

    ipc_sync #(.W(1)) u_rx_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       (rx_pin),
        .q       (rx_sync)
    );

    ipc_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_capture (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .in_valid  (st_ff.pend),
        .in_ready  (fifo_in_ready),
        .in_data   (st_ff.shreg),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out_data)
    );

    // ****************************************************************
    // mode decode
    // ****************************************************************
    assign active = communication_mode_select == COMM_MODE_IR;
    always_comb begin
        if (!active) begin
            mode = MODE_OFF;
        end else if (st_ff.tx_pulse_length == TX_LEN_PASS) begin
            mode = MODE_PASS;
        end else if (st_ff.tx_pulse_length == TX_LEN_316) begin
            mode = MODE_316;
        end else begin
            mode = MODE_FIXED;
        end
    end
    assign modulating = (mode == MODE_316) || (mode == MODE_FIXED);
    // reserved selections 0001..0111 fall back to the pin
    assign src = (active && st_ff.event_channel_select[EVENT_EN_BIT])
               ? event_channel_n[st_ff.event_channel_select[1:0]] : rx_sync;
    assign baud_rise  = baud_clk && !st_ff.baud_prev;
    assign period_x3  = {2'b00, st_ff.period} + {1'b0, st_ff.period, 1'b0};
    assign len316     = (period_x3[17:4] == 14'h0000) ? 16'h0001
                      : {2'b00, period_x3[17:4]};
    assign period_min = (st_ff.period == 16'h0000) ? 16'h0001 : st_ff.period;

    // ****************************************************************
    // bus handshakes
    // ****************************************************************
    assign awready  = !st_ff.aw_have && !st_ff.bvalid;
    assign wready   = !st_ff.w_have && !st_ff.bvalid;
    assign arready  = !st_ff.rvalid;
    assign fifo_pop = arvalid && arready && (araddr == ADDR_DATA);
    assign status_word = (32'(active) << ST_ACTIVE) | (32'(modulating) << ST_MOD)
                       | (32'(fifo_out_valid) << ST_AVAIL)
                       | (32'(st_ff.overrun) << ST_OVERRUN)
                       | (32'(st_ff.tx_pin) << ST_TXPIN) | (32'(st_ff.rxd) << ST_RXD);

    always_comb begin
        nxt_st = st_ff;
        // ************************************************************
        // register write
        // ************************************************************
        if (st_ff.bvalid && bready) begin
            nxt_st.bvalid = 1'b0;
        end
        if (awvalid && awready) begin
            nxt_st.aw_have = 1'b1;
            nxt_st.aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            nxt_st.w_have = 1'b1;
            nxt_st.w_data = wdata[7:0];
            nxt_st.w_be   = wstrb[0];
        end
        if (nxt_st.aw_have && nxt_st.w_have) begin
            nxt_st.aw_have = 1'b0;
            nxt_st.w_have  = 1'b0;
            nxt_st.bvalid  = 1'b1;
            nxt_st.bresp   = RESP_OKAY;
            unique case (nxt_st.aw_addr)
                ADDR_TX_LEN: begin
                    if (nxt_st.w_be) nxt_st.tx_pulse_length = nxt_st.w_data;
                end
                ADDR_RX_FILT: begin
                    if (nxt_st.w_be) nxt_st.rx_pulse_filter = nxt_st.w_data;
                end
                ADDR_CTRL: begin
                    // bits 7:4 are not stored and read back as zero
                    if (nxt_st.w_be) nxt_st.event_channel_select = nxt_st.w_data[3:0];
                end
                ADDR_STATUS: begin
                    if (nxt_st.w_be && nxt_st.w_data[ST_OVERRUN]) nxt_st.overrun = 1'b0;
                end
                ADDR_DATA: begin
                end
                default: begin
                    nxt_st.bresp = RESP_SLVERR;
                end
            endcase
        end
        // ************************************************************
        // register read
        // ************************************************************
        if (st_ff.rvalid && rready) begin
            nxt_st.rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp  = RESP_OKAY;
            unique case (araddr)
                ADDR_TX_LEN:  nxt_st.rdata = {24'h000000, st_ff.tx_pulse_length};
                ADDR_RX_FILT: nxt_st.rdata = {24'h000000, st_ff.rx_pulse_filter};
                ADDR_CTRL:    nxt_st.rdata = {28'h0000000, st_ff.event_channel_select};
                ADDR_STATUS:  nxt_st.rdata = status_word;
                ADDR_DATA: begin
                    nxt_st.rdata = fifo_out_valid ? {24'h000000, fifo_out_data} : 32'h00000000;
                end
                default: begin
                    nxt_st.rdata = 32'h00000000;
                    nxt_st.rresp = RESP_SLVERR;
                end
            endcase
        end
        // ************************************************************
        // baud period measurement
        // ************************************************************
        nxt_st.baud_prev = baud_clk;
        if (baud_rise) begin
            nxt_st.period  = (st_ff.per_cnt == CNT_MAX) ? CNT_MAX : st_ff.per_cnt + 16'h0001;
            nxt_st.per_cnt = 16'h0000;
        end else if (st_ff.per_cnt != CNT_MAX) begin
            nxt_st.per_cnt = st_ff.per_cnt + 16'h0001;
        end
        // ************************************************************
        // transmit shaping
        // ************************************************************
        if (st_ff.pulse_cnt != 16'h0000) begin
            nxt_st.pulse_cnt = st_ff.pulse_cnt - 16'h0001;
        end
        if (!modulating) begin
            nxt_st.pulse_cnt = 16'h0000;
        end else if (baud_rise && !uart_txd) begin
            // uses the period measured up to the previous edge, one bit old
            nxt_st.pulse_cnt = (mode == MODE_FIXED)
                             ? {8'h00, st_ff.tx_pulse_length} : len316;
        end
        unique case (mode)
            MODE_OFF, MODE_PASS: nxt_st.tx_pin = uart_txd;
            MODE_316, MODE_FIXED: nxt_st.tx_pin = nxt_st.pulse_cnt != 16'h0000;
        endcase
        // ************************************************************
        // receive filter and decode
        // ************************************************************
        nxt_st.rx_last = src;
        if (src == st_ff.rx_last) begin
            nxt_st.run = (st_ff.run == 8'hFF) ? 8'hFF : st_ff.run + 8'h01;
        end else begin
            nxt_st.run = 8'h00;
        end
        // run counts repeats, so run >= x means x+1 equal samples
        if ((st_ff.rx_pulse_filter == 8'h00) || (nxt_st.run >= st_ff.rx_pulse_filter)) begin
            nxt_st.filt = src;
        end
        if (st_ff.hold != 16'h0000) begin
            nxt_st.hold = st_ff.hold - 16'h0001;
        end
        if (!modulating) begin
            nxt_st.hold = 16'h0000;
        end else if (nxt_st.filt && !st_ff.filt) begin
            // stretch to a bit period so the transceiver samples it mid bit
            nxt_st.hold = period_min;
        end
        unique case (mode)
            MODE_OFF:  nxt_st.rxd = rx_sync;
            MODE_PASS: nxt_st.rxd = src;
            MODE_316, MODE_FIXED: nxt_st.rxd = nxt_st.hold == 16'h0000;
        endcase
        // ************************************************************
        // decoded bit capture, stalls while a finished byte waits on a full buffer
        // ************************************************************
        if (st_ff.pend && fifo_in_ready) begin
            nxt_st.pend = 1'b0;
        end
        if (active && baud_rise) begin
            if (st_ff.pend && !fifo_in_ready) begin
                nxt_st.overrun = 1'b1;
            end else begin
                nxt_st.shreg  = {st_ff.rxd, st_ff.shreg[7:1]};
                nxt_st.bitcnt = st_ff.bitcnt + 3'h1;
                if (st_ff.bitcnt == 3'h7) nxt_st.pend = 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff                      <= '0;
            st_ff.tx_pulse_length      <= TX_LEN_RST;
            st_ff.rx_pulse_filter      <= RX_FILT_RST;
            st_ff.event_channel_select <= EVENT_SEL_RST;
            st_ff.tx_pin               <= 1'b0;
            st_ff.rxd                  <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign bvalid   = st_ff.bvalid;
    assign bresp    = st_ff.bresp;
    assign rvalid   = st_ff.rvalid;
    assign rdata    = st_ff.rdata;
    assign rresp    = st_ff.rresp;
    assign tx_pin   = st_ff.tx_pin;
    assign uart_rxd = st_ff.rxd;

    // ****************************************************************
    // checks
    // ****************************************************************
    logic [15:0] hi_cnt_ff;
    logic        armed_ff;
    // checks wait one cycle after reset leaves, state still holds reset values then
    always_ff @(posedge aclk) begin
        armed_ff <= aresetn;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn || !st_ff.tx_pin) begin
            hi_cnt_ff <= 16'h0000;
        end else begin
            hi_cnt_ff <= hi_cnt_ff + 16'h0001;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn || !armed_ff);

    a_bypass_tx: assert property (!active |=> tx_pin == $past(uart_txd))
        else $error("tx pin not bypassed outside infrared mode");
    a_bypass_rx: assert property (!active ##1 !active |=> uart_rxd == $past(rx_sync))
        else $error("rx not bypassed outside infrared mode");
    a_pass_tx: assert property (mode == MODE_PASS |=> tx_pin == $past(uart_txd))
        else $error("pass-through transmit altered");
    a_event_rx: assert property (mode == MODE_PASS && st_ff.event_channel_select[3]
        && st_ff.rx_pulse_filter == 8'h00 |=> uart_rxd == $past(src))
        else $error("event channel not routed to receiver");
    a_pin_rx: assert property (mode == MODE_PASS && st_ff.event_channel_select == 4'h0
        |-> src == rx_sync)
        else $error("pin not selected with no event input");
    a_zero_pulse: assert property (modulating && baud_rise && !uart_txd |=> tx_pin)
        else $error("no pulse for zero bit");
    a_one_idle: assert property (modulating && baud_rise && uart_txd
        && st_ff.pulse_cnt <= 16'h0001 |=> !tx_pin)
        else $error("pulse sent for one bit");
    a_pulse_start: assert property ($rose(tx_pin) && $past(modulating)
        |-> $past(baud_rise))
        else $error("pulse not aligned to baud edge");
    a_fixed_len: assert property ($fell(tx_pin) && $past(mode) == MODE_FIXED
        && $past(st_ff.period) > {8'h00, st_ff.tx_pulse_length}
        |-> hi_cnt_ff == {8'h00, $past(st_ff.tx_pulse_length)})
        else $error("fixed pulse length wrong");
    a_filt_off: assert property (st_ff.rx_pulse_filter == 8'h00 |=> st_ff.filt == $past(src))
        else $error("unfiltered input not followed");
    a_filt_short: assert property (st_ff.rx_pulse_filter != 8'h00 && $changed(st_ff.filt)
        |-> $past(nxt_st.run) >= $past(st_ff.rx_pulse_filter))
        else $error("filter accepted too few samples");
    a_demod_zero: assert property (modulating ##1 $rose(st_ff.filt) && modulating
        |-> !uart_rxd)
        else $error("accepted pulse not decoded as zero");
    a_overrun_set: assert property (active && baud_rise && st_ff.pend && !fifo_in_ready
        |=> st_ff.overrun)
        else $error("overrun lost");

    c_fixed_pulse: cover property (mode == MODE_FIXED && $fell(tx_pin));
    c_316_pulse: cover property (mode == MODE_316 && $fell(tx_pin));
    c_event_rx: cover property (active && st_ff.event_channel_select[3] && $fell(uart_rxd));
    c_fifo_full: cover property (!fifo_in_ready);
endmodule

/* File: inc/ipc_pkg.sv */
// Purpose: shared constants and types of the infrared pulse codec
// Assumes: 32-bit AXI4-Lite register bus, one aligned word per register
// Notes:   register data sits in the low byte, upper bits read as zero
package ipc_pkg;
    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [4:0] ADDR_TX_LEN  = 5'h00;
    localparam logic [4:0] ADDR_RX_FILT = 5'h04;
    localparam logic [4:0] ADDR_CTRL    = 5'h08;
    localparam logic [4:0] ADDR_STATUS  = 5'h0C;
    localparam logic [4:0] ADDR_DATA    = 5'h10;
    // ****************************************************************
    // reset values and codes
    // ****************************************************************
    localparam logic [7:0] TX_LEN_RST     = 8'h00;
    localparam logic [7:0] RX_FILT_RST    = 8'h00;
    localparam logic [3:0] EVENT_SEL_RST  = 4'h0;
    localparam logic [7:0] TX_LEN_316     = 8'h00;
    localparam logic [7:0] TX_LEN_PASS    = 8'hFF;
    localparam logic [1:0] COMM_MODE_IR   = 2'b10;
    localparam logic [1:0] RESP_OKAY      = 2'b00;
    localparam logic [1:0] RESP_SLVERR    = 2'b10;
    localparam logic [15:0] CNT_MAX       = 16'hFFFF;
    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int EVENT_EN_BIT = 3;
    localparam int ST_ACTIVE    = 0;
    localparam int ST_MOD       = 1;
    localparam int ST_AVAIL     = 2;
    localparam int ST_OVERRUN   = 3;
    localparam int ST_TXPIN     = 4;
    localparam int ST_RXD       = 5;
    // ****************************************************************
    // capture buffer shape
    // ****************************************************************
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 16;

    typedef enum logic [1:0] {
        MODE_OFF   = 2'b00,
        MODE_316   = 2'b01,
        MODE_FIXED = 2'b10,
        MODE_PASS  = 2'b11
    } ipc_mode_type;
endpackage

/* File: src/ipc_sync.sv */
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: input is asynchronous to aclk
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module ipc_sync #(
    parameter int W = 1
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } ipc_sync_type;

    ipc_sync_type st_ff;
    ipc_sync_type nxt_st;

    always_comb begin
        nxt_st      = st_ff;
        nxt_st.meta = d;
        nxt_st.sync = st_ff.meta;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q = st_ff.sync;
endmodule

/* File: src/ipc_fifo.sv */
// Purpose: capture buffer between bit capture and register reads
// Assumes: DEPTH is a power of two
// Notes:   read data always come from a register holding the head word
`timescale 1ns/1ps
module ipc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 cnt;
        logic [WIDTH-1:0]            dout;
    } ipc_fifo_type;

    ipc_fifo_type st_ff;
    ipc_fifo_type nxt_st;
    logic         push;
    logic         pop;

    assign in_ready  = st_ff.cnt != (AW+1)'(DEPTH);
    assign out_valid = st_ff.cnt != '0;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = st_ff.dout;

    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.mem[st_ff.wr] = in_data;
            nxt_st.wr            = st_ff.wr + AW'(1);
        end
        if (pop) begin
            nxt_st.rd = st_ff.rd + AW'(1);
        end
        nxt_st.cnt  = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
        // head word re-registered every cycle, so a push into empty shows next cycle
        nxt_st.dout = nxt_st.mem[nxt_st.rd];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule

/* File: tb/ipc_far_model.sv */
// Purpose: far side model, optics pulses and transceiver baud clock
// Assumes: one baud rising edge per bit, BAUD clocks per bit
// Notes:   rx_pin idles low, the optics give no light between pulses
`timescale 1ns/1ps
module ipc_far_model #(
    parameter int BAUD = 32
) (
    input  wire logic       aclk,
    input  wire logic       go,
    input  wire logic [7:0] pulse_w,
    output logic            baud_clk,
    output logic            rx_pin
);
    int bc = 0;
    int pc = 0;
    initial baud_clk = 1'b0;
    initial rx_pin = 1'b0;
    always @(posedge aclk) begin
        bc <= (bc == BAUD - 1) ? 0 : bc + 1;
        baud_clk <= (bc < BAUD / 2);
        pc <= go ? int'(pulse_w) : (pc > 0 ? pc - 1 : 0);
        rx_pin <= go ? (pulse_w != 8'h00) : (pc > 1);
    end
endmodule

/* File: tb/test_infrared_pulse_codec.sv */
// Purpose: self-checking bench of the infrared pulse codec
// Assumes: baud period of 32 clocks from the far side model
// Notes:   expectations come from integer arithmetic on the settings
`timescale 1ns/1ps
module test_infrared_pulse_codec;
    import ipc_pkg::*;
    logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic        arvalid = 0, rready = 0, uart_txd = 1, go = 0, bq = 0, pt;
    logic [4:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, rv;
    logic [3:0]  wstrb = 4'hF, event_channel_n = 0;
    logic [1:0]  bresp, rresp, rr, communication_mode_select = 0;
    logic [7:0]  pulse_w = 0;
    logic        awready, wready, bvalid, arready, rvalid, uart_rxd, tx_pin, baud_clk, rx_pin;
    int          errors = 0, n_tests = 0, seed = 89844, n, x;
    int          exp_q[$];
    always #50 aclk = ~aclk;
    always @(posedge aclk) bq <= baud_clk;
    ipc_codec u_ipc_codec (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .communication_mode_select, .baud_clk, .uart_txd,
        .uart_rxd, .tx_pin, .rx_pin, .event_channel_n);
    ipc_far_model u_ipc_far_model (.aclk, .go, .pulse_w, .baud_clk, .rx_pin);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // both channels offered together, each released once taken
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk(bresp, RESP_OKAY);
    endtask
    task automatic rd(input logic [4:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        rv = rdata;
        rr = rresp;
    endtask
    task automatic rise;
        do @(posedge aclk); while (!(baud_clk && !bq));
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // watchdog, nearly four times the expected run
    initial begin
        #2000000;
        errors++;
        report_and_stop;
    end
    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            rd(5'(i * 4));
            chk(rv, 32'h0);
        end
        rd(5'h14);
        chk(rr, RESP_SLVERR);
        wstrb <= 4'h0;
        wr(ADDR_TX_LEN, 8'h33);
        wstrb <= 4'hF;
        rd(ADDR_TX_LEN);
        chk(rv, 32'h0);
        $display("registers done");
        communication_mode_select <= COMM_MODE_IR;
        repeat (140) rise;
        rd(ADDR_STATUS);
        chk(rv[3:0], 4'hF);
        // no light on the pin, so every captured bit decodes as one
        repeat (16) exp_q.push_back(32'hFF);
        for (int i = 0; i < 16; i++) begin
            rd(ADDR_DATA);
            chk(rv, exp_q.pop_front());
        end
        communication_mode_select <= 2'b00;
        wr(ADDR_STATUS, 8'h08);
        rd(ADDR_STATUS);
        chk(rv[3], 1'b0);
        $display("buffer done");
        communication_mode_select <= COMM_MODE_IR;
        uart_txd <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            x = (k == 0) ? 0 : (k == 1) ? 1 : 2 + {$random(seed)} % 20;
            wr(ADDR_TX_LEN, x[7:0]);
            repeat (4) rise;
            @(posedge aclk);
            chk(tx_pin, 1'b1);
            n = 0;
            while (tx_pin === 1'b1) begin
                n++;
                @(posedge aclk);
            end
            chk(n, x == 0 ? 32 * 3 / 16 : x);
        end
        uart_txd <= 1'b1;
        rise;
        @(posedge aclk);
        chk(tx_pin, 1'b0);
        rd(ADDR_STATUS);
        chk({rv[5:4], rv[1:0]}, 4'hB);
        $display("transmit done");
        for (int m = 0; m < 2; m++) begin
            communication_mode_select <= m ? COMM_MODE_IR : 2'b01;
            wr(ADDR_TX_LEN, m ? TX_LEN_PASS : 8'h05);
            repeat (8) begin
                @(posedge aclk);
                pt = uart_txd;
                uart_txd <= $random(seed);
                @(posedge aclk);
                chk(tx_pin, pt);
            end
        end
        for (int c = 0; c < 6; c++) begin
            x = c < 4 ? 8 + c : c - 4;
            wr(ADDR_CTRL, x[7:0]);
            repeat (8) begin
                @(posedge aclk);
                pt = (c < 4) ? event_channel_n[c] : 1'b0;
                event_channel_n <= $random(seed);
                @(posedge aclk);
                chk(uart_rxd, pt);
            end
        end
        wr(ADDR_CTRL, 8'h00);
        $display("pass and events done");
        wr(ADDR_TX_LEN, TX_LEN_316);
        x = 1 + {$random(seed)} % 8;
        wr(ADDR_RX_FILT, x[7:0]);
        for (int w = 0; w < 2; w++) begin
            @(posedge aclk);
            pulse_w <= x[7:0] + w[7:0];
            go <= 1'b1;
            @(posedge aclk);
            go <= 1'b0;
            pt = 1'b1;
            repeat (24) begin
                @(posedge aclk);
                pt = pt & uart_rxd;
            end
            chk(pt, w == 0);
            repeat (60) @(posedge aclk);
        end
        $display("receive done");
        report_and_stop;
    end
endmodule
